// *** pkg/pio_pkg.sv ***
package pio_pkg;
    localparam int WIDTH = 16;
    localparam logic [15:0] IMPL_MASK = 16'hFFFF;
    localparam logic [15:0] SHARED_MASK = 16'hFFFF;
    localparam logic [15:0] ANALOG_CAPABLE = 16'hFFFF;
    localparam logic [15:0] DIR_RESET = 16'hFFFF;
    localparam logic [15:0] LAT_RESET = 16'h0000;
    localparam logic [1:0] SEL_DIR = 2'h0;
    localparam logic [1:0] SEL_LAT = 2'h1;
    localparam logic [1:0] SEL_PORT = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;
endpackage

// *** rtl/pio_sync_reg.sv ***
module pio_sync_reg #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] next_q;
    always_comb begin
        next_q = d_i;
        if (!rst_b_i) begin
            next_q = '0;
        end
    end
    always_ff @(posedge clk_i) begin
        q_o <= next_q;
    end
endmodule

// *** rtl/shared_parallel_io_port.sv ***
module shared_parallel_io_port #(
    parameter logic [15:0] IMPL   = pio_pkg::IMPL_MASK,
    parameter logic [15:0] SHARED = pio_pkg::SHARED_MASK,
    parameter logic [15:0] ANCAP  = pio_pkg::ANALOG_CAPABLE
) (
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_B_I,
    // CPU access
    input  wire logic        WR_EN_I,
    input  wire logic        RD_EN_I,
    input  wire logic [1:0]  SEL_I,
    input  wire logic [15:0] WDATA_I,
    output logic      [15:0] RDATA_O,
    // Analog configuration
    input  wire logic [15:0] ANALOG_PIN_SELECT_I,
    // Peripherals
    input  wire logic [15:0] PERIPH_EN_I,
    input  wire logic [15:0] PERIPH_OE_I,
    input  wire logic [15:0] PERIPH_DATA_I,
    // Pads
    input  wire logic [15:0] PAD_I,
    output logic      [15:0] PAD_O,
    output logic      [15:0] PAD_OE_O,
    output logic      [15:0] PERIPH_IN_O,
    output logic      [15:0] ANALOG_INPUT_PIN_EN_O
);
    localparam logic [15:0] MUXED = IMPL & SHARED;

    logic [15:0] pin_direction_reg;
    logic [15:0] output_latch_reg;
    logic [15:0] pin_level_reg;
    logic [15:0] next_pin_direction_reg;
    logic [15:0] next_output_latch_reg;
    logic [15:0] next_rdata;
    logic [15:0] next_pad;
    logic [15:0] next_pad_oe;
    logic [15:0] next_periph_in;
    logic [15:0] next_analog_en;
    logic [15:0] analog_sel;
    logic [15:0] periph_drive;

    assign analog_sel   = ANALOG_PIN_SELECT_I & ANCAP & IMPL;
    // Pins the peripheral owns this cycle
    assign periph_drive = PERIPH_EN_I & PERIPH_OE_I & MUXED;

    // Pin sampling register
    pio_sync_reg #(
        .W(16)
    ) u_pin_sample (
        .clk_i   (CLOCK_I),
        .rst_b_i (RST_B_I),
        .d_i     (PAD_I & IMPL),
        .q_o     (pin_level_reg)
    );

    always_comb begin
        next_pin_direction_reg = pin_direction_reg;
        next_output_latch_reg  = output_latch_reg;
        if (WR_EN_I && SEL_I == pio_pkg::SEL_DIR) begin
            next_pin_direction_reg = WDATA_I & IMPL;
        end
        if (WR_EN_I && (SEL_I == pio_pkg::SEL_LAT || SEL_I == pio_pkg::SEL_PORT)) begin
            next_output_latch_reg = WDATA_I & IMPL;
        end
        if (!RST_B_I) begin
            next_pin_direction_reg = pio_pkg::DIR_RESET & IMPL;
            next_output_latch_reg  = pio_pkg::LAT_RESET & IMPL;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        pin_direction_reg <= next_pin_direction_reg;
        output_latch_reg  <= next_output_latch_reg;
    end

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_pin
            always_comb begin
                if (!RST_B_I || !IMPL[g]) begin
                    next_pad[g]    = 1'b0;
                    next_pad_oe[g] = 1'b0;
                end else if (MUXED[g] && PERIPH_EN_I[g] && PERIPH_OE_I[g]) begin
                    next_pad[g]    = PERIPH_DATA_I[g];
                    next_pad_oe[g] = 1'b1;
                end else begin
                    next_pad[g]    = output_latch_reg[g];
                    next_pad_oe[g] = ~pin_direction_reg[g];
                end
            end
        end
    endgenerate

    always_comb begin
        next_rdata = RDATA_O;
        if (RD_EN_I) begin
            case (SEL_I)
                pio_pkg::SEL_DIR:  next_rdata = pin_direction_reg;
                pio_pkg::SEL_LAT:  next_rdata = output_latch_reg;
                pio_pkg::SEL_PORT: next_rdata = pin_level_reg & ~analog_sel;
                default:           next_rdata = 16'h0000;
            endcase
        end
        next_periph_in = pin_level_reg & ~analog_sel;
        next_analog_en = analog_sel;
        if (!RST_B_I) begin
            next_rdata     = 16'h0000;
            next_periph_in = 16'h0000;
            next_analog_en = 16'h0000;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        RDATA_O               <= next_rdata;
        PAD_O                 <= next_pad;
        PAD_OE_O              <= next_pad_oe;
        PERIPH_IN_O           <= next_periph_in;
        ANALOG_INPUT_PIN_EN_O <= next_analog_en;
    end

    a_reset_inputs: assert property (@(posedge CLOCK_I)
        !RST_B_I |=> pin_direction_reg == (pio_pkg::DIR_RESET & IMPL))
        else $error("direction not input after reset");

    a_periph_owns: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (PERIPH_EN_I & PERIPH_OE_I & MUXED) != 16'h0000 |=>
        ((PAD_OE_O & $past(PERIPH_EN_I & PERIPH_OE_I & MUXED)) == $past(PERIPH_EN_I & PERIPH_OE_I & MUXED)))
        else $error("peripheral drive not taken");

    a_port_dir: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        ((PAD_OE_O ^ ~$past(pin_direction_reg)) & ~$past(PERIPH_EN_I & PERIPH_OE_I & MUXED) & IMPL) == 16'h0000)
        else $error("pad enable does not follow direction");

    sequence s_port_write;
        WR_EN_I && SEL_I == pio_pkg::SEL_PORT;
    endsequence

    sequence s_latch_read;
        RD_EN_I && SEL_I == pio_pkg::SEL_LAT;
    endsequence

    a_latch_read: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        s_port_write ##1 s_latch_read |=> RDATA_O == ($past(WDATA_I, 2) & IMPL))
        else $error("latch read mismatch after port write");

    a_none_read: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        RD_EN_I && SEL_I == pio_pkg::SEL_NONE |=> RDATA_O == 16'h0000)
        else $error("unused select read nonzero");

    a_dir_read: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        RD_EN_I && SEL_I == pio_pkg::SEL_DIR |=> RDATA_O == $past(pin_direction_reg))
        else $error("direction read mismatch");

    a_port_data: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        ((PAD_O ^ $past(output_latch_reg)) & ~$past(periph_drive) & IMPL) == 16'h0000)
        else $error("pad data does not follow latch");

    a_periph_data: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        ((PAD_O ^ $past(PERIPH_DATA_I)) & $past(periph_drive)) == 16'h0000)
        else $error("peripheral data not on pad");

    a_periph_in_mask: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        (PERIPH_IN_O & $past(analog_sel)) == 16'h0000)
        else $error("analog pin seen as digital");

    a_analog_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        RD_EN_I && SEL_I == pio_pkg::SEL_PORT |=> (RDATA_O & $past(analog_sel)) == 16'h0000)
        else $error("analog pin read nonzero");

    a_unimpl_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        ((RDATA_O | PAD_OE_O | pin_direction_reg | output_latch_reg) & ~IMPL) == 16'h0000)
        else $error("unimplemented bit nonzero");

    a_sample_delay: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        $past(RST_B_I) |-> pin_level_reg == ($past(PAD_I) & IMPL))
        else $error("pin sample not one cycle late");

    a_analog_en: assert property (@(posedge CLOCK_I) disable iff (!RST_B_I)
        ##1 ANALOG_INPUT_PIN_EN_O == $past(analog_sel))
        else $error("converter enable mismatch");
endmodule

// *** verif/pad_world_model.sv ***
module pad_world_model (
    // Device side
    input  wire logic [15:0] pad_o_i,
    input  wire logic [15:0] pad_oe_i,
    // Outside world
    input  wire logic [15:0] ext_i,
    output logic      [15:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board drives only where the device lets go
    assign level_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & ext_i);
endmodule

// *** verif/test_shared_parallel_io_port.sv ***
module test_shared_parallel_io_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic [15:0] wdata = 16'h0000, ana = 16'h0000, p_en = 16'h0000, p_oe = 16'h0000;
    logic [15:0] p_dat = 16'h0000, rdata, pad_o, pad_oe, lvl, p_in, ana_en;
    int          fails = 0, n_checks = 0;
    always #12.5 clk = ~clk;
    shared_parallel_io_port u_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .WR_EN_I(wr), .RD_EN_I(rd),
        .SEL_I(sel), .WDATA_I(wdata), .RDATA_O(rdata), .ANALOG_PIN_SELECT_I(ana),
        .PERIPH_EN_I(p_en), .PERIPH_OE_I(p_oe), .PERIPH_DATA_I(p_dat), .PAD_I(lvl),
        .PAD_O(pad_o), .PAD_OE_O(pad_oe), .PERIPH_IN_O(p_in), .ANALOG_INPUT_PIN_EN_O(ana_en));
    pad_world_model u_pads (.pad_o_i(pad_o), .pad_oe_i(pad_oe), .ext_i(16'h5A5A), .level_o(lvl));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [1:0] s, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        sel <= s;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        idle(2);
    endtask
    task automatic rd_chk(input logic [1:0] s, input logic [15:0] exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        sel <= s;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(3000 * 25);
        fails++;
        finish_test();
    end
    initial begin
        idle(3);
        rst_b <= 1'b1;
        rd_chk(pio_pkg::SEL_DIR, 16'hFFFF, "dir reset");
        rd_chk(pio_pkg::SEL_LAT, 16'h0000, "lat reset");
        wr_reg(pio_pkg::SEL_LAT, 16'hA5C3);
        rd_chk(pio_pkg::SEL_LAT, 16'hA5C3, "lat rd");
        wr_reg(pio_pkg::SEL_PORT, 16'h1234);
        rd_chk(pio_pkg::SEL_LAT, 16'h1234, "port wr");
        rd_chk(pio_pkg::SEL_PORT, 16'h5A5A, "pins");
        chk("oe in", 16'h0000, pad_oe);
        @(posedge clk);
        ana <= 16'h00F0;
        idle(3);
        rd_chk(pio_pkg::SEL_PORT, 16'h5A0A, "analog rd");
        chk("periph in ana", 16'h5A0A, p_in);
        chk("conv en", 16'h00F0, ana_en);
        ana <= 16'h0000;
        wr_reg(pio_pkg::SEL_DIR, 16'hFF00);
        chk("oe out", 16'h00FF, pad_oe);
        chk("pad out", 16'h0034, pad_o & 16'h00FF);
        rd_chk(pio_pkg::SEL_PORT, 16'h5A34, "mixed");
        @(posedge clk);
        p_en <= 16'hFFFF;
        p_oe <= 16'h0F0F;
        p_dat <= 16'hAAAA;
        idle(3);
        chk("mux oe", 16'h0FFF, pad_oe);
        chk("mux dat", 16'h0A3A, pad_o & 16'h0FFF);
        rd_chk(pio_pkg::SEL_PORT, 16'h5A3A, "periph rd");
        chk("periph in", 16'h5A3A, p_in);
        @(posedge clk);
        wr <= 1'b1;
        sel <= pio_pkg::SEL_PORT;
        wdata <= 16'h0F0F;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        sel <= pio_pkg::SEL_LAT;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("b2b lat", 16'h0F0F, rdata);
        rd_chk(pio_pkg::SEL_NONE, 16'h0000, "none");
        finish_test();
    end
endmodule
